// >>> rtl/serial_dac_input.sv
`timescale 1ns/1ps
`default_nettype none

`include "serial_dac_regs.svh"

// Function
// - sample data input into shift register on every rising serial clock edge
// - update strobe copies shift register into holding register and converter together
// - update input tied high statically selects asynchronous mode
// - asynchronous words framed by start and stop bit; frame with high stop bit updates
// - three-wire data output follows the sixteenth stage itself
// - any number chained; one shared strobe updates all together
// - fault flag is active-low open drain for wired-OR sharing
// - fault asserts when output stage headroom nearly exhausted
// - code zero gives range bottom, all ones full scale minus one step
// - converter word is 16-bit straight binary, monotonic
// - second-order sigma-delta single-bit stream switches current source
// - in three-wire mode rising update edge loads converter in parallel
// - asynchronous framing error gives positive pulse on data output after stop
// - clear forces range minimum and holds it; input register unaffected
module serial_dac_input (
  // core clock and reset
  input  wire logic  clock,
  input  wire logic  reset_n,
  // serial link, clocked by the host
  input  wire logic  link_clock,
  input  wire logic  data_in,
  input  wire logic  latch_in,
  output logic       data_out,
  // asynchronous clear
  input  wire logic  clear_in,
  // output stage headroom sense and fault pin
  input  wire logic  headroom_low,
  output logic       fault_n_o,
  output logic       fault_n_oe,
  // converter side
  output logic       dac_bit,
  output logic [15:0] held_code
);

  // ---------------- link domain ----------------
  logic [15:0]                    shift_r;
  logic [1:0]                     lmode_sync_r;
  logic                           ss_mode_async;
  logic [1:0]                     lrst_r;
  logic                           lrst_n;
  serial_dac_pkg::rx_state_type   rx_state_r;
  logic [3:0]                     ovs_r;
  logic [3:0]                     bit_cnt_r;
  logic [15:0]                    rx_word_r;
  logic [15:0]                    word_r;
  logic                           word_tgl_r;
  logic [3:0]                     ferr_cnt_r;
  logic                           data_out_r;

  // reset released into the link domain
  always_ff @(posedge link_clock or negedge reset_n) begin
    if (!reset_n) begin
      lrst_r <= 2'b00;
    end else begin
      lrst_r <= {lrst_r[0], 1'b1};
    end
  end
  assign lrst_n = lrst_r[1];

  // mode strap seen on the link clock
  always_ff @(posedge link_clock or negedge reset_n) begin
    if (!reset_n) begin
      lmode_sync_r <= 2'b00;
    end else begin
      lmode_sync_r <= {lmode_sync_r[0], latch_in};
    end
  end
  assign ss_mode_async = lmode_sync_r[1] & lrst_n;

  // three-wire shift register, msb first
  always_ff @(posedge link_clock or negedge reset_n) begin
    if (!reset_n) begin
      shift_r <= `DAC_CODE_RESET;
    end else begin
      shift_r <= {shift_r[14:0], data_in};
    end
  end

  // asynchronous receiver on the 16x clock
  always_ff @(posedge link_clock or negedge reset_n) begin
    if (!reset_n) begin
      rx_state_r <= serial_dac_pkg::RX_IDLE;
      ovs_r      <= 4'h0;
      bit_cnt_r  <= 4'h0;
      rx_word_r  <= `DAC_CODE_RESET;
      word_r     <= `DAC_CODE_RESET;
      word_tgl_r <= 1'b0;
      ferr_cnt_r <= 4'h0;
    end else begin
      if (ferr_cnt_r != 4'h0) begin
        ferr_cnt_r <= ferr_cnt_r - 4'h1;
      end
      case (rx_state_r)
        serial_dac_pkg::RX_IDLE: begin
          ovs_r <= 4'h0;
          if (ss_mode_async && !data_in) begin
            rx_state_r <= serial_dac_pkg::RX_START;
          end
        end
        serial_dac_pkg::RX_START: begin
          ovs_r <= ovs_r + 4'h1;
          if (ovs_r == `OVS_MID) begin
            ovs_r      <= 4'h0;
            bit_cnt_r  <= 4'h0;
            rx_state_r <= data_in ? serial_dac_pkg::RX_IDLE : serial_dac_pkg::RX_DATA;
          end
        end
        serial_dac_pkg::RX_DATA: begin
          ovs_r <= ovs_r + 4'h1;
          if (ovs_r == `OVS_LAST) begin
            rx_word_r <= {rx_word_r[14:0], data_in};
            bit_cnt_r <= bit_cnt_r + 4'h1;
            if (bit_cnt_r == 4'hf) begin
              rx_state_r <= serial_dac_pkg::RX_STOP;
            end
          end
        end
        default: begin
          ovs_r <= ovs_r + 4'h1;
          if (ovs_r == `OVS_LAST) begin
            rx_state_r <= serial_dac_pkg::RX_IDLE;
            if (data_in) begin
              word_r     <= rx_word_r;
              word_tgl_r <= !word_tgl_r;
            end else begin
              ferr_cnt_r <= `FERR_PULSE_LEN;
            end
          end
        end
      endcase
    end
  end

  // data output: chain bit in three-wire, error pulse in asynchronous
  always_ff @(posedge link_clock or negedge reset_n) begin
    if (!reset_n) begin
      data_out_r <= 1'b0;
    end else begin
      // shift_r[14] becomes the last stage on this edge, so the pin tracks the stage itself
      data_out_r <= ss_mode_async ? (ferr_cnt_r != 4'h0) : shift_r[14];
    end
  end

  // ---------------- core domain ----------------
  logic [1:0]  latch_sync_r;
  logic        latch_d_r;
  logic [2:0]  tgl_sync_r;
  logic [1:0]  clr_sync_r;
  logic [1:0]  dout_sync_r;
  logic [1:0]  flt_sync_r;
  logic        fifo_in_valid;
  logic [15:0] fifo_in_data;
  logic        fifo_in_ready;
  logic        fifo_out_valid;
  logic [15:0] fifo_out_data;
  logic        strobe_rise;

  // synchronisers for pins and link toggle
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      latch_sync_r <= 2'b00;
      latch_d_r    <= 1'b0;
      tgl_sync_r   <= 3'b000;
      clr_sync_r   <= 2'b00;
      flt_sync_r   <= 2'b00;
      dout_sync_r  <= 2'b00;
    end else begin
      latch_sync_r <= {latch_sync_r[0], latch_in};
      latch_d_r    <= latch_sync_r[1];
      tgl_sync_r   <= {tgl_sync_r[1:0], word_tgl_r};
      clr_sync_r   <= {clr_sync_r[0], clear_in};
      flt_sync_r   <= {flt_sync_r[0], headroom_low};
      dout_sync_r  <= {dout_sync_r[0], data_out_r};
    end
  end

  assign strobe_rise = latch_sync_r[1] && !latch_d_r;

  // the shift register is quiet while the strobe is high, so sampling is safe
  assign fifo_in_valid = strobe_rise || (tgl_sync_r[2] != tgl_sync_r[1]);
  assign fifo_in_data  = strobe_rise ? shift_r : word_r;

  code_fifo #(
    .WIDTH (`DAC_WORD_BITS),
    .DEPTH (`FIFO_DEPTH),
    .AW    (`FIFO_ADDR_BITS)
  ) u_fifo (
    .clock     (clock),
    .reset_n   (reset_n),
    .in_data   (fifo_in_data),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out_data),
    .out_valid (fifo_out_valid),
    .out_ready (!clr_sync_r[1])
  );

  // holding register: loaded from buffer, forced to minimum by clear
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      held_code <= `DAC_CODE_RESET;
    end else if (clr_sync_r[1]) begin
      held_code <= `DAC_CODE_MIN;
    end else if (fifo_out_valid) begin
      held_code <= fifo_out_data;
    end
  end

  // open-drain fault pin, pulls low while headroom is short
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      fault_n_o  <= 1'b0;
      fault_n_oe <= 1'b0;
      data_out   <= 1'b0;
    end else begin
      fault_n_o  <= 1'b0;
      fault_n_oe <= flt_sync_r[1];
      data_out   <= dout_sync_r[1];
    end
  end

  sd_modulator u_mod (
    .clock   (clock),
    .reset_n (reset_n),
    .code    (held_code),
    .bit_out (dac_bit)
  );

endmodule

`default_nettype wire

// >>> common/serial_dac_regs.svh
`ifndef SERIAL_DAC_REGS_SVH
`define SERIAL_DAC_REGS_SVH

// word and frame geometry
`define DAC_WORD_BITS      16
`define DAC_CODE_MSB       15
`define DAC_CODE_MIN       16'h0000
`define DAC_CODE_RESET     16'h0000
// oversampling of the asynchronous receiver
`define OVS_RATE           16
`define OVS_MID            4'h7
`define OVS_LAST           4'hf
// framing error pulse length in link clocks
`define FERR_PULSE_LEN     4'hf
// buffer geometry
`define FIFO_DEPTH         16
`define FIFO_ADDR_BITS     4
// modulator integrator width and feedback magnitude
`define MOD_ACC_BITS       20
`define MOD_FULL_SCALE     20'h10000

`endif

// >>> common/serial_dac_pkg.sv
package serial_dac_pkg;

  // asynchronous receiver states
  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b10,
    RX_STOP  = 2'b11
  } rx_state_type;

endpackage

// >>> rtl/code_fifo.sv
`timescale 1ns/1ps
`default_nettype none

// small synchronous word buffer with registered read data
module code_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16,
  parameter int AW    = 4
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             reset_n,
  // fill side
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  // drain side
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      count_r;
  logic             push;
  logic             pop;

  // handshake terms; read data register holds head when valid
  assign in_ready = (count_r != (AW+1)'(DEPTH));
  assign push     = in_valid && in_ready;
  assign pop      = out_valid && out_ready;

  // storage write
  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  // pointers and fill count
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + AW'(1);
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + AW'(1);
      end
      count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // head register: refilled whenever empty-register or popped
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      out_data  <= '0;
      out_valid <= 1'b0;
    end else if (!out_valid || pop) begin
      out_valid <= (count_r != '0) && !(count_r == (AW+1)'(1) && out_valid);
      out_data  <= mem[rd_ptr_r + AW'(out_valid)];
    end
  end

endmodule

`default_nettype wire

// >>> rtl/sd_modulator.sv
`timescale 1ns/1ps
`default_nettype none

`include "serial_dac_regs.svh"

// second-order single-bit modulator driving the current switch
module sd_modulator (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        reset_n,
  // held code
  input  wire logic [15:0] code,
  // bit stream
  output logic             bit_out
);

  localparam int AB = `MOD_ACC_BITS;

  logic signed [AB-1:0] int1_r;
  logic signed [AB-1:0] int2_r;
  logic signed [AB-1:0] fb;
  logic signed [AB-1:0] x;
  logic signed [AB-1:0] int1_nxt;
  logic signed [AB-1:0] int2_nxt;

  // straight binary input, feedback 0 or full scale keeps it monotonic
  assign x        = AB'({4'h0, code});
  assign fb       = bit_out ? AB'(`MOD_FULL_SCALE) : '0;
  assign int1_nxt = int1_r + x - fb;
  assign int2_nxt = int2_r + int1_nxt - fb;

  // two cascaded integrators, quantiser on the second
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      int1_r  <= '0;
      int2_r  <= '0;
      bit_out <= 1'b0;
    end else begin
      int1_r  <= int1_nxt;
      int2_r  <= int2_nxt;
      bit_out <= (int2_nxt >= 0) && (code != '0);
    end
  end

endmodule

`default_nettype wire

// >>> bench/serial_dac_monitor.sv
`timescale 1ns/1ps
`default_nettype none

// pin-level checks of the serial input block
module serial_dac_monitor (
  // core clock and reset
  input wire logic        clock,
  input wire logic        reset_n,
  // watched pins
  input wire logic        link_clock,
  input wire logic        latch_in,
  input wire logic        data_out,
  input wire logic        clear_in,
  input wire logic        headroom_low,
  input wire logic        fault_n_o,
  input wire logic        fault_n_oe,
  input wire logic [15:0] held_code
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  logic [5:0] pulse_len_r;

  // length of a high stretch on the data output in framed mode
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n)
      pulse_len_r <= 6'h00;
    else if (data_out && latch_in)
      pulse_len_r <= pulse_len_r + {5'h00, ~&pulse_len_r};
    else
      pulse_len_r <= 6'h00;
  end

  property p_fault_raise;
    $rose(headroom_low) |-> ##[1:3] fault_n_oe;
  endproperty
  a_fault_raise: assert property (p_fault_raise) else $error("fault flag late");
  property p_fault_release;
    !headroom_low [*4] |-> !fault_n_oe;
  endproperty
  a_fault_release: assert property (p_fault_release) else $error("fault flag stuck");
  property p_fault_pin;
    fault_n_oe |-> fault_n_o == 1'b0;
  endproperty
  a_fault_pin: assert property (p_fault_pin) else $error("fault pin drives high");
  property p_clear_min;
    clear_in [*6] |-> held_code == 16'h0000;
  endproperty
  a_clear_min: assert property (p_clear_min) else $error("clear not at minimum");
  property p_clear_hold;
    $fell(clear_in) |-> (held_code == 16'h0000) [*4];
  endproperty
  a_clear_hold: assert property (p_clear_hold) else $error("code left minimum");
  property p_held_quiet;
    (!latch_in && !clear_in) [*8] |-> $stable(held_code);
  endproperty
  a_held_quiet: assert property (p_held_quiet) else $error("code moved unasked");
  property p_out_still;
    (!latch_in && $stable(link_clock)) [*6] |-> $stable(data_out);
  endproperty
  a_out_still: assert property (p_out_still) else $error("chain bit moved");
  property p_pulse_short;
    latch_in |-> pulse_len_r <= 6'h18;
  endproperty
  a_pulse_short: assert property (p_pulse_short) else $error("error pulse long");
endmodule

bind serial_dac_input serial_dac_monitor mon (
  .clock(clock), .reset_n(reset_n), .link_clock(link_clock),
  .latch_in(latch_in), .data_out(data_out), .clear_in(clear_in),
  .headroom_low(headroom_low), .fault_n_o(fault_n_o),
  .fault_n_oe(fault_n_oe), .held_code(held_code)
);

`default_nettype wire

// >>> bench/host_serial_model.sv
`timescale 1ns/1ps
`default_nettype none

// host serial port: clock stands still between link tasks
module host_serial_model (
  // serial link toward the device
  output logic link_clock,
  output logic data_in,
  output logic latch_in
);
  // idle link
  initial begin
    link_clock = 1'b0;
    data_in = 1'b0;
    latch_in = 1'b0;
  end

  // one link period of 125 ns, data set while clock low
  task automatic tick(input logic d);
    data_in = d;
    #62.5 link_clock = 1'b1;
    #62.5 link_clock = 1'b0;
  endtask

  // three-wire bits msb first; released line shows inverse
  task automatic shift(input logic [31:0] w, input int n);
    for (int i = n - 1; i >= 0; i--)
      tick(w[i]);
    data_in = ~data_in;
  endtask

  // update strobe with the clock held still
  task automatic strobe();
    #400 latch_in = 1'b1;
    #800 latch_in = 1'b0;
  endtask

  // static high strobe pin selects framed mode
  task automatic go_async();
    latch_in = 1'b1;
    data_in = 1'b1;
    // let the rising strap be taken before the link moves, then clock the mode in
    #400;
    repeat (4) tick(1'b1);
    #4000;
  endtask

  // framed word, sixteen clocks a bit, then idle clocks
  task automatic frame(input logic [15:0] w, input logic stop);
    repeat (16) tick(1'b0);
    for (int i = 15; i >= 0; i--)
      repeat (16) tick(w[i]);
    repeat (16) tick(stop);
    repeat (48) tick(1'b1);
  endtask
endmodule

`default_nettype wire

// >>> bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic        clock = 1'b0;
  logic        reset_n;
  logic        clear_in;
  logic        headroom_low;
  wire         link_clock;
  wire         data_in;
  wire         latch_in;
  logic        data_out;
  logic        fault_n_o;
  logic        fault_n_oe;
  logic        dac_bit;
  logic [15:0] held_code;
  logic [15:0] exp_q [$];
  logic [15:0] last_exp = 16'h0000;
  logic [15:0] seen_code = 16'h0000;
  logic [15:0] codes [4] = '{16'hffff, 16'h8000, 16'h0000, 16'h0000};
  logic [15:0] w_far;
  logic [15:0] w_near;
  logic [31:0] rnd = 32'h0000a91e;
  logic        pulse_seen = 1'b0;
  int          ones [4] = '{0, 0, 0, 0};
  int          err_count = 0;
  int          comparisons = 0;

  serial_dac_input dut (.clock(clock), .reset_n(reset_n), .link_clock(link_clock),
    .data_in(data_in), .latch_in(latch_in), .data_out(data_out), .clear_in(clear_in),
    .headroom_low(headroom_low), .fault_n_o(fault_n_o), .fault_n_oe(fault_n_oe),
    .dac_bit(dac_bit), .held_code(held_code));
  host_serial_model host (.link_clock(link_clock), .data_in(data_in), .latch_in(latch_in));

  always #50 clock = ~clock;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic expect_code(input logic [15:0] v);
    if (v !== last_exp)
      exp_q.push_back(v);
    last_exp = v;
  endtask

  task automatic conclude();
    $display("comparisons %0d errors %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // oldest note is compared whenever the held code moves
  always @(posedge clock) begin
    if (reset_n && held_code !== seen_code) begin
      seen_code = held_code;
      if (exp_q.size() != 0)
        check("held_code", exp_q.pop_front(), held_code);
      else
        check("held_code", last_exp, held_code);
    end
    if (reset_n && latch_in && data_out === 1'b1)
      pulse_seen <= 1'b1;
  end

  // hang guard
  initial begin
    repeat (100000) @(posedge clock);
    err_count++;
    $display("BAD timeout expected finish seen hang");
    conclude();
  end

  initial begin
    reset_n = 1'b0;
    clear_in = 1'b0;
    headroom_low = 1'b0;
    cycles(16);
    reset_n = 1'b1;
    cycles(4);
    // extremes, midscale and a random word, stream density of each
    rnd = lfsr(rnd);
    codes[3] = rnd[15:0];
    for (int i = 0; i < 4; i++) begin
      host.shift({16'h0000, codes[i]}, 16);
      expect_code(codes[i]);
      host.strobe();
      cycles(40);
      for (int k = 0; k < 256; k++) begin
        cycles(1);
        ones[i] += int'(dac_bit === 1'b1);
      end
    end
    check("density order", 16'h0001, {15'h0000, ones[0] > ones[1] && ones[1] > ones[2]});
    check("midscale density", 16'h0001, {15'h0000, ones[1] >= 112 && ones[1] <= 144});
    // two chained words, nearest device keeps the trailing one
    rnd = lfsr(rnd);
    w_far = rnd[15:0];
    rnd = lfsr(rnd);
    w_near = rnd[15:0];
    host.shift({w_far, w_near}, 32);
    cycles(8);
    check("data_out", {15'h0000, w_near[15]}, {15'h0000, data_out});
    expect_code(w_near);
    host.strobe();
    cycles(20);
    // clear to minimum, then reload the untouched input register
    expect_code(16'h0000);
    clear_in = 1'b1;
    cycles(10);
    clear_in = 1'b0;
    cycles(10);
    expect_code(w_near);
    host.strobe();
    cycles(20);
    // fault flag follows the headroom sense
    headroom_low = 1'b1;
    cycles(4);
    check("fault_n_oe", 16'h0001, {15'h0000, fault_n_oe});
    check("fault_n_o", 16'h0000, {15'h0000, fault_n_o});
    headroom_low = 1'b0;
    cycles(4);
    check("fault_n_oe", 16'h0000, {15'h0000, fault_n_oe});
    // framed mode: good frame updates, bad stop bit pulses
    host.go_async();
    rnd = lfsr(rnd);
    expect_code(rnd[15:0]);
    pulse_seen = 1'b0;
    host.frame(rnd[15:0], 1'b1);
    cycles(10);
    check("error pulse", 16'h0000, {15'h0000, pulse_seen});
    host.frame(~rnd[15:0], 1'b0);
    cycles(10);
    check("error pulse", 16'h0001, {15'h0000, pulse_seen});
    for (int k = 0; k < 200 && exp_q.size() != 0; k++)
      cycles(1);
    check("pending updates", 16'h0000, 16'(exp_q.size()));
    conclude();
  end
endmodule

`default_nettype wire
